//--- pkg/bz_pkg.sv
// shared constants and types of the border zone layout generator
package bz_pkg;
    // ****************************************
    // sector limits and zone sizes
    // ****************************************
    localparam logic [31:0] MIN_BO_LAST = 32'h0003FEFF;
    localparam logic [31:0] SIZE1_LAST = 32'h000B25FF;
    localparam logic [31:0] SIZE2_LAST = 32'h001656FF;
    localparam logic [11:0] SIZE1_BLOCKS = 12'h734;
    localparam logic [11:0] SIZE2_BLOCKS = 12'h98A;
    localparam logic [11:0] SIZE3_BLOCKS = 12'hB9C;
    localparam logic [31:0] ALIGN_MASK = 32'h0000000F;
    localparam int SECTOR_SHIFT = 4;
    // ****************************************
    // unit positions
    // ****************************************
    localparam logic [11:0] RECORD_LAST = 12'h004;
    localparam logic [11:0] STOP_A = 12'h025;
    localparam logic [11:0] STOP_B = 12'h026;
    localparam logic [11:0] FILL_MIN_M = 12'h027;
    localparam logic [11:0] TAIL_GAP = 12'h017;
    localparam logic [11:0] MK1 = 12'h000;
    localparam logic [11:0] MK2 = 12'h00A;
    localparam logic [11:0] MK3 = 12'h014;
    localparam logic [11:0] GUARD_OFS = 12'h002;
    localparam logic [11:0] BI_PFI_LAST = 12'h005;
    localparam logic [11:0] BI_LAST = 12'h006;
    localparam logic [11:0] BZ_EXTRA = 12'h007;
    // ****************************************
    // format information byte positions and data zone start sector
    // ****************************************
    localparam logic [10:0] PB_LAYER = 11'h000;
    localparam logic [10:0] PB_RATE = 11'h001;
    localparam logic [10:0] PB_ALLOC_FIRST = 11'h004;
    localparam logic [10:0] PB_ALLOC_LAST = 11'h00F;
    localparam logic [10:0] PB_BO_FIRST = 11'h020;
    localparam logic [10:0] PB_BI_LAST = 11'h027;
    localparam logic [10:0] PB_REMAP = 11'h02A;
    localparam logic [31:0] DZ_START = 32'h00030000;
    // ****************************************
    // types
    // ****************************************
    typedef enum logic [3:0] {
        CT_RECORD, CT_ZERO, CT_STOP, CT_MARK_NONE, CT_MARK_ZERO,
        CT_MARK_PFI2, CT_GUARD, CT_LOSS, CT_PFI
    } content_t;
    typedef enum logic [1:0] {AR_DATA, AR_LEADOUT, AR_MIDDLE} area_t;
    typedef struct packed {
        logic [31:0] addr;
        content_t code;
        area_t area;
        logic dtype;
    } unit_word_t;
endpackage

//--- pkg/bz_stream_if.sv
// valid/ready stream carrier between generator and unit fifo
`timescale 1ns/1ps
interface bz_stream_if #(parameter int W = 39);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

//--- rtl/bz_unit_fifo.sv
// unit descriptor fifo with registered output stage
`timescale 1ns/1ps
module bz_unit_fifo #(
    parameter int WIDTH = 39,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic arst_n,
    bz_stream_if.snk wr,
    bz_stream_if.src rd
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [AW:0] cnt_q;
    logic ov_q;
    logic [WIDTH-1:0] od_q;
    wire push = wr.valid && wr.ready;
    wire load = (cnt_q != '0) && (!ov_q || rd.ready);

    assign wr.ready = cnt_q < (AW+1)'(DEPTH);
    assign rd.valid = ov_q;
    assign rd.data = od_q;

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp_q] <= wr.data;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
            ov_q <= 1'b0;
            od_q <= '0;
        end else begin
            wp_q <= push ? wp_q + 1'b1 : wp_q;
            rp_q <= load ? rp_q + 1'b1 : rp_q;
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(load);
            ov_q <= load ? 1'b1 : (rd.ready ? 1'b0 : ov_q);
            od_q <= load ? mem[rp_q] : od_q;
        end
    end
endmodule

//--- rtl/border_zone_layout_generator.sv
// border zone unit sequencer and updated format information patcher
`timescale 1ns/1ps
module border_zone_layout_generator (
    input wire logic SYS_CLK,
    input wire logic ARST_N,
    input wire logic START,
    input wire logic [31:0] BO_START,
    input wire logic [31:0] BI_START,
    input wire logic [11:0] M_POS,
    input wire logic [11:0] N_POS,
    input wire logic JOINED_MIDDLE,
    input wire logic MARKER_PFI,
    input wire logic FINALIZE,
    input wire logic [7:0] LAYER_IND,
    input wire logic [7:0] MAX_RATE,
    input wire logic [7:0] REMAP_FLAGS,
    input wire logic [23:0] DZ_MAX_SECTOR,
    input wire logic [23:0] L0_END_SECTOR,
    output logic OUT_VALID,
    input wire logic OUT_READY,
    output logic [31:0] OUT_ADDR,
    output logic [3:0] OUT_CONTENT,
    output logic [1:0] OUT_AREA,
    output logic OUT_DTYPE,
    output logic BUSY,
    output logic DONE,
    output logic REFUSED,
    output logic [31:0] MARKER_ADDR,
    input wire logic PFI_RD_EN,
    input wire logic [10:0] PFI_RD_IDX,
    input wire logic [7:0] PRE_BYTE,
    output logic PFI_RD_VALID,
    output logic [7:0] PFI_RD_DATA
);
    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [11:0] zone_size(input logic [31:0] s);
        if (s <= bz_pkg::SIZE1_LAST) begin
            return bz_pkg::SIZE1_BLOCKS;
        end else if (s <= bz_pkg::SIZE2_LAST) begin
            return bz_pkg::SIZE2_BLOCKS;
        end
        return bz_pkg::SIZE3_BLOCKS;
    endfunction

    function automatic logic [7:0] sel_byte(input logic [31:0] w, input logic [1:0] pos);
        return 8'(w >> {2'h3 - pos, 3'h0});
    endfunction

    typedef enum {S_IDLE, S_RUN} state_t;
    localparam int UW = $bits(bz_pkg::unit_word_t);

    state_t state_q;
    logic [11:0] up_q;
    logic [11:0] m_q;
    logic [11:0] n_q;
    logic [11:0] zsize_q;
    logic [31:0] bo_q;
    logic [31:0] bi_q;
    logic joined_q;
    logic mpfi_q;
    logic final_q;
    logic [7:0] layer_q;
    logic [7:0] rate_q;
    logic [7:0] remap_q;
    logic [23:0] dzmax_q;
    logic [23:0] l0end_q;
    logic done_q;
    logic busy_q;
    logic refused_q;
    logic [31:0] maddr_q;
    logic pfi_v_q;
    logic [7:0] pfi_d_q;

    bz_stream_if #(.W(UW)) fi ();
    bz_stream_if #(.W(UW)) fo ();

    // ****************************************
    // start checks
    // ****************************************
    wire idle = state_q == S_IDLE;
    wire try_start = START && idle;
    wire lo_ok = BO_START > bz_pkg::MIN_BO_LAST;
    wire al_ok = (BO_START & bz_pkg::ALIGN_MASK) == '0;
    wire end_ok = BO_START <= {8'h00, L0_END_SECTOR};
    wire [11:0] zsize = zone_size(BO_START);
    wire [11:0] span = N_POS + bz_pkg::BZ_EXTRA;
    wire len_ok = JOINED_MIDDLE ? (span <= zsize) : (span == zsize);
    wire m_ok = (M_POS >= bz_pkg::FILL_MIN_M) && (M_POS + bz_pkg::TAIL_GAP <= N_POS);
    wire start_ok = lo_ok && al_ok && end_ok && len_ok && m_ok;
    wire accept = try_start && start_ok;
    wire [32:0] start_sum = {1'b0, BO_START} + {1'b0, BI_START};

    // ****************************************
    // unit classification
    // ****************************************
    wire next_area = bi_q != '0;
    wire [11:0] rel = up_q - m_q;
    wire past_m = up_q >= m_q;
    wire is_mark = past_m && (rel == bz_pkg::MK1 || rel == bz_pkg::MK1 + 12'h001 ||
        rel == bz_pkg::MK2 || rel == bz_pkg::MK2 + 12'h001 ||
        rel == bz_pkg::MK3 || rel == bz_pkg::MK3 + 12'h001);
    wire is_guard = past_m && (rel == bz_pkg::MK1 + bz_pkg::GUARD_OFS ||
        rel == bz_pkg::MK2 + bz_pkg::GUARD_OFS ||
        rel == bz_pkg::MK3 + bz_pkg::GUARD_OFS);
    wire mark_rec = final_q || next_area;
    wire is_pfi = (up_q > n_q) && (up_q <= n_q + bz_pkg::BI_PFI_LAST);
    wire is_last = up_q == n_q + bz_pkg::BI_LAST;
    wire is_stop = up_q == bz_pkg::STOP_A || up_q == bz_pkg::STOP_B;
    bz_pkg::content_t mark_code;
    bz_pkg::content_t cur_code;
    bz_pkg::area_t cur_area;
    bz_pkg::unit_word_t cur_word;

    assign mark_code = final_q ? bz_pkg::CT_MARK_ZERO :
        !next_area ? bz_pkg::CT_MARK_NONE :
        mpfi_q ? bz_pkg::CT_MARK_PFI2 : bz_pkg::CT_MARK_ZERO;
    assign cur_code = up_q <= bz_pkg::RECORD_LAST ? bz_pkg::CT_RECORD :
        is_stop ? bz_pkg::CT_STOP :
        is_mark ? mark_code :
        is_guard ? (mark_rec ? bz_pkg::CT_LOSS : bz_pkg::CT_GUARD) :
        up_q == n_q ? bz_pkg::CT_LOSS :
        is_pfi ? bz_pkg::CT_PFI :
        is_last ? bz_pkg::CT_GUARD : bz_pkg::CT_ZERO;
    assign cur_area = is_stop ? bz_pkg::AR_LEADOUT :
        (is_mark && final_q) ? bz_pkg::AR_MIDDLE : bz_pkg::AR_DATA;
    assign cur_word.addr = bo_q + (32'(up_q) << bz_pkg::SECTOR_SHIFT);
    assign cur_word.code = cur_code;
    assign cur_word.area = cur_area;
    assign cur_word.dtype = cur_code != bz_pkg::CT_RECORD;

    wire push = (state_q == S_RUN) && fi.ready;
    assign fi.valid = state_q == S_RUN;
    assign fi.data = cur_word;

    // ****************************************
    // sequencer
    // ****************************************
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            state_q <= S_IDLE;
            up_q <= '0;
            done_q <= 1'b0;
            busy_q <= 1'b0;
            refused_q <= 1'b0;
            maddr_q <= '0;
        end else begin
            done_q <= push && is_last;
            refused_q <= try_start && !start_ok;
            maddr_q <= accept ? start_sum[32:1] : maddr_q;
            case (state_q)
                S_IDLE: begin
                    up_q <= '0;
                    busy_q <= accept;
                    state_q <= accept ? S_RUN : S_IDLE;
                end
                S_RUN: begin
                    up_q <= push ? up_q + 12'h001 : up_q;
                    busy_q <= !(push && is_last);
                    state_q <= (push && is_last) ? S_IDLE : S_RUN;
                end
                default: begin
                    busy_q <= 1'b0;
                    state_q <= S_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            m_q <= '0;
            n_q <= '0;
            zsize_q <= '0;
            bo_q <= '0;
            bi_q <= '0;
            joined_q <= 1'b0;
            mpfi_q <= 1'b0;
            final_q <= 1'b0;
            layer_q <= '0;
            rate_q <= '0;
            remap_q <= '0;
            dzmax_q <= '0;
            l0end_q <= '0;
        end else if (accept) begin
            m_q <= M_POS;
            n_q <= N_POS;
            zsize_q <= zsize;
            bo_q <= BO_START;
            bi_q <= BI_START;
            joined_q <= JOINED_MIDDLE;
            mpfi_q <= MARKER_PFI;
            final_q <= FINALIZE;
            layer_q <= LAYER_IND;
            rate_q <= MAX_RATE;
            remap_q <= REMAP_FLAGS;
            dzmax_q <= DZ_MAX_SECTOR;
            l0end_q <= L0_END_SECTOR;
        end
    end

    // ****************************************
    // updated format information byte patch
    // ****************************************
    wire [10:0] alloc_k = PFI_RD_IDX - bz_pkg::PB_ALLOC_FIRST;
    wire [10:0] bz_k = PFI_RD_IDX - bz_pkg::PB_BO_FIRST;
    wire in_alloc = PFI_RD_IDX >= bz_pkg::PB_ALLOC_FIRST &&
        PFI_RD_IDX <= bz_pkg::PB_ALLOC_LAST;
    wire in_bz = PFI_RD_IDX >= bz_pkg::PB_BO_FIRST && PFI_RD_IDX <= bz_pkg::PB_BI_LAST;
    wire [31:0] alloc_word = alloc_k[3:2] == 2'h0 ? bz_pkg::DZ_START :
        alloc_k[3:2] == 2'h1 ? {8'h00, dzmax_q} : {8'h00, l0end_q};
    wire [31:0] bz_word = bz_k[2] ? bi_q : bo_q;
    wire [7:0] patched = PFI_RD_IDX == bz_pkg::PB_LAYER ? layer_q :
        PFI_RD_IDX == bz_pkg::PB_RATE ? rate_q :
        in_alloc ? sel_byte(alloc_word, alloc_k[1:0]) :
        in_bz ? sel_byte(bz_word, bz_k[1:0]) :
        PFI_RD_IDX == bz_pkg::PB_REMAP ? remap_q : PRE_BYTE;

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            pfi_v_q <= 1'b0;
            pfi_d_q <= '0;
        end else begin
            pfi_v_q <= PFI_RD_EN;
            pfi_d_q <= PFI_RD_EN ? patched : pfi_d_q;
        end
    end

    // ****************************************
    // unit fifo and outputs
    // ****************************************
    bz_unit_fifo #(.WIDTH(UW), .DEPTH(8)) u_fifo (
        .clk(SYS_CLK),
        .arst_n(ARST_N),
        .wr(fi.snk),
        .rd(fo.src)
    );

    bz_pkg::unit_word_t out_word;
    assign out_word = fo.data;
    assign fo.ready = OUT_READY;
    assign OUT_VALID = fo.valid;
    assign OUT_ADDR = out_word.addr;
    assign OUT_CONTENT = out_word.code;
    assign OUT_AREA = out_word.area;
    assign OUT_DTYPE = out_word.dtype;
    assign BUSY = busy_q;
    assign DONE = done_q;
    assign REFUSED = refused_q;
    assign MARKER_ADDR = maddr_q;
    assign PFI_RD_VALID = pfi_v_q;
    assign PFI_RD_DATA = pfi_d_q;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!ARST_N);

    property p_low_refused;
        try_start && BO_START <= bz_pkg::MIN_BO_LAST |=> REFUSED && !BUSY;
    endproperty
    a_low_refused: assert property (p_low_refused)
        else $error("low border-out start not refused");

    property p_align_refused;
        try_start && BO_START[3:0] != 4'h0 |=> REFUSED && !BUSY;
    endproperty
    a_align_refused: assert property (p_align_refused)
        else $error("misaligned border-out start not refused");

    property p_size;
        BUSY && !joined_q |-> n_q + bz_pkg::BZ_EXTRA == zsize_q;
    endproperty
    a_size: assert property (p_size)
        else $error("zone length differs from size band");

    property p_step;
        push ##1 push |-> cur_word.addr == $past(cur_word.addr) + 32'h00000010;
    endproperty
    a_step: assert property (p_step)
        else $error("unit address step is not one block");

    property p_marker_addr;
        accept |=> MARKER_ADDR == 32'(($past(BO_START) + 33'($past(BI_START))) >> 1);
    endproperty
    a_marker_addr: assert property (p_marker_addr)
        else $error("marker address wrong");

    property p_rmd;
        push && up_q <= bz_pkg::RECORD_LAST |-> cur_code == bz_pkg::CT_RECORD && !cur_word.dtype;
    endproperty
    a_rmd: assert property (p_rmd)
        else $error("record copy unit wrong");

    property p_stop;
        push && is_stop |-> cur_code == bz_pkg::CT_STOP && cur_area == bz_pkg::AR_LEADOUT;
    endproperty
    a_stop: assert property (p_stop)
        else $error("stop block wrong");

    property p_unrec;
        push && is_mark && bi_q == '0 && !final_q |-> cur_code == bz_pkg::CT_MARK_NONE;
    endproperty
    a_unrec: assert property (p_unrec)
        else $error("marker recorded without next area");

    property p_final;
        push && is_mark && final_q |-> cur_area == bz_pkg::AR_MIDDLE;
    endproperty
    a_final: assert property (p_final)
        else $error("finalized marker lacks middle attribute");

    property p_bo_byte;
        PFI_RD_EN && PFI_RD_IDX == bz_pkg::PB_BO_FIRST |=> PFI_RD_DATA == bo_q[31:24];
    endproperty
    a_bo_byte: assert property (p_bo_byte)
        else $error("border-out start byte wrong");

    property p_border_in;
        push && up_q > n_q && up_q - n_q <= bz_pkg::BI_PFI_LAST |-> cur_code == bz_pkg::CT_PFI;
    endproperty
    a_border_in: assert property (p_border_in)
        else $error("border-in format unit wrong");

    property p_guard_loss;
        push && past_m && rel == bz_pkg::MK2 + bz_pkg::GUARD_OFS && (final_q || bi_q != '0)
            |-> cur_code == bz_pkg::CT_LOSS;
    endproperty
    a_guard_loss: assert property (p_guard_loss)
        else $error("guard after recorded marker not loss");

    property p_marker_pfi;
        push && is_mark && !final_q && bi_q != '0 && mpfi_q |-> cur_code == bz_pkg::CT_MARK_PFI2;
    endproperty
    a_marker_pfi: assert property (p_marker_pfi)
        else $error("marker lacks twice-written format info");
endmodule

//--- test/bz_unit_sink.sv
// write channel model that takes unit descriptors and can stall
`timescale 1ns/1ps
module bz_unit_sink (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic clr,
    input wire logic stall,
    input wire logic valid,
    input wire logic [31:0] addr,
    input wire logic [3:0] code,
    input wire logic [1:0] area,
    input wire logic dtype,
    output logic ready,
    output int count
);
    logic [4:0] cnt_q;
    logic [31:0] addr_m [0:4095];
    logic [3:0] code_m [0:4095];
    logic [1:0] area_m [0:4095];
    logic dtype_m [0:4095];
    // slow mode takes 4 of every 32 cycles so the fifo fills up
    assign ready = !stall || (cnt_q[4:2] == 3'h0);
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= 5'h00;
            count <= 0;
        end else begin
            cnt_q <= cnt_q + 5'h01;
            if (clr) begin
                count <= 0;
            end else if (valid && ready) begin
                addr_m[count] <= addr;
                code_m[count] <= code;
                area_m[count] <= area;
                dtype_m[count] <= dtype;
                count <= count + 1;
            end
        end
    end
endmodule

//--- test/border_zone_layout_generator_bench.sv
// self-checking bench of the border zone layout generator
`timescale 1ns/1ps
module border_zone_layout_generator_bench;
    logic clk, arst_n, start, jm, mpfi, fin, stall, clr, pen;
    logic [31:0] bo, bi;
    logic [11:0] m, n;
    logic [10:0] pidx;
    logic [7:0] pre;
    logic ov, ordy, odt, busy, done, refused, pvalid;
    logic [31:0] oaddr, maddr;
    logic [3:0] ocode;
    logic [1:0] oarea;
    logic [7:0] pdata;
    int err_count, cmp_count, cyc, cnt;
    // ****************************************
    // clock, reset, instances
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    border_zone_layout_generator uut (.SYS_CLK(clk), .ARST_N(arst_n), .START(start),
        .BO_START(bo), .BI_START(bi), .M_POS(m), .N_POS(n), .JOINED_MIDDLE(jm),
        .MARKER_PFI(mpfi), .FINALIZE(fin), .LAYER_IND(8'h3C), .MAX_RATE(8'hC3),
        .REMAP_FLAGS(8'h96), .DZ_MAX_SECTOR(24'h12ABCD), .L0_END_SECTOR(24'h1FFFFF),
        .OUT_VALID(ov), .OUT_READY(ordy), .OUT_ADDR(oaddr), .OUT_CONTENT(ocode),
        .OUT_AREA(oarea), .OUT_DTYPE(odt), .BUSY(busy), .DONE(done), .REFUSED(refused),
        .MARKER_ADDR(maddr), .PFI_RD_EN(pen), .PFI_RD_IDX(pidx), .PRE_BYTE(pre),
        .PFI_RD_VALID(pvalid), .PFI_RD_DATA(pdata));
    bz_unit_sink sink (.clk(clk), .arst_n(arst_n), .clr(clr), .stall(stall), .valid(ov),
        .addr(oaddr), .code(ocode), .area(oarea), .dtype(odt), .ready(ordy), .count(cnt));
    // ****************************************
    // reporting
    // ****************************************
    task automatic complete_run();
        $display("checks %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 80000) begin
            err_count++;
            complete_run();
        end
    end
    // ****************************************
    // expected unit layout
    // ****************************************
    function automatic logic [3:0] exp_code(int up, int mp, int np, logic rec, logic [3:0] mk);
        if (up <= 4) return bz_pkg::CT_RECORD;
        if (up == 37 || up == 38) return bz_pkg::CT_STOP;
        if (up == np) return bz_pkg::CT_LOSS;
        if (up > np && up <= np + 5) return bz_pkg::CT_PFI;
        if (up == np + 6) return bz_pkg::CT_GUARD;
        for (int o = 0; o <= 20; o += 10) begin
            if (up == mp + o || up == mp + o + 1) return mk;
            if (up == mp + o + 2) return rec ? bz_pkg::CT_LOSS : bz_pkg::CT_GUARD;
        end
        return bz_pkg::CT_ZERO;
    endfunction
    // ****************************************
    // shared zone run
    // ****************************************
    task automatic run_zone(input logic [31:0] b0, b1, input int mp, np,
                            input logic j, p, f, s);
        logic rec;
        logic [3:0] mk, c;
        @(negedge clk);
        {bo, bi, m, n, jm, mpfi, fin, stall} = {b0, b1, mp[11:0], np[11:0], j, p, f, s};
        start = 1'b1;
        clr = 1'b1;
        @(negedge clk);
        start = 1'b0;
        clr = 1'b0;
        chk(busy, 1);
        chk(maddr, (b0 + b1) >> 1);
        for (int i = 0; i < 30000 && done !== 1'b1; i++) @(negedge clk);
        chk(done, 1);
        chk(busy, 0);
        for (int i = 0; i < 400 && cnt != np + 7; i++) @(negedge clk);
        chk(cnt, np + 7);
        rec = (b1 != 0) || f;
        mk = f ? bz_pkg::CT_MARK_ZERO : (b1 == 0) ? bz_pkg::CT_MARK_NONE :
             p ? bz_pkg::CT_MARK_PFI2 : bz_pkg::CT_MARK_ZERO;
        for (int k = 0; k < np + 7; k++) begin
            c = exp_code(k, mp, np, rec, mk);
            chk(sink.addr_m[k], b0 + 16 * k);
            chk(sink.code_m[k], c);
            chk(sink.dtype_m[k], k > 4);
            chk(sink.area_m[k], c == bz_pkg::CT_STOP ? bz_pkg::AR_LEADOUT :
                (f && c == mk) ? bz_pkg::AR_MIDDLE : bz_pkg::AR_DATA);
        end
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic refusals();
        logic [31:0] tb [8] = '{32'h03FEF0, 32'h0B0008, 32'h0B25F0, 32'h0B2600,
                                32'h200000, 32'h0B0000, 32'h0B0000, 32'h0B0000};
        int tm [8] = '{39, 39, 39, 39, 39, 38, 1815, 39};
        int tn [8] = '{1837, 1837, 2435, 1837, 2965, 1837, 1837, 1836};
        for (int i = 0; i < 8; i++) begin
            @(negedge clk);
            {bo, bi, m, n, jm} = {tb[i], 32'h0, tm[i][11:0], tn[i][11:0], 1'b0};
            start = 1'b1;
            @(negedge clk);
            start = 1'b0;
            chk(refused, 1);
            chk(busy, 0);
            @(negedge clk);
            chk(refused, 0);
        end
    endtask
    task automatic band1_no_next();
        run_zone(32'h03FF00, 32'h0, 39, 1837, 1'b0, 1'b1, 1'b0, 1'b0);
    endtask
    task automatic band2_pfi_marker_stalled();
        run_zone(32'h0B2600, 32'h0C0000, 100, 2435, 1'b0, 1'b1, 1'b0, 1'b1);
    endtask
    task automatic joined_short_zero_marker();
        run_zone(32'h0B25F0, 32'h0B4000, 40, 93, 1'b1, 1'b0, 1'b0, 1'b0);
    endtask
    task automatic band3_finalized();
        run_zone(32'h165700, 32'h1A0000, 500, 2965, 1'b0, 1'b1, 1'b1, 1'b0);
    endtask
    task automatic format_info_read();
        logic [7:0] e;
        logic [63:0] sec;
        logic [7:0] dz [12] = '{8'h00, 8'h03, 8'h00, 8'h00, 8'h00, 8'h12, 8'hAB, 8'hCD,
                                8'h00, 8'h1F, 8'hFF, 8'hFF};
        sec = {32'h165700, 32'h1A0000};
        for (int i = 0; i <= 48; i++) begin
            @(negedge clk);
            if (i > 0) begin
                e = (i - 1) ^ 8'h5A;
                if (i == 1) e = 8'h3C;
                if (i == 2) e = 8'hC3;
                if (i >= 5 && i <= 16) e = dz[i - 5];
                if (i >= 33 && i <= 40) e = sec[63 - 8 * (i - 33) -: 8];
                if (i == 43) e = 8'h96;
                chk(pvalid, 1);
                chk(pdata, e);
            end
            pen = (i < 48);
            pidx = i[10:0];
            pre = i[7:0] ^ 8'h5A;
        end
        @(negedge clk);
        chk(pvalid, 0);
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        {arst_n, start, jm, mpfi, fin, stall, clr, pen} = 8'h00;
        {bo, bi, m, n, pidx, pre} = '0;
        err_count = 0;
        cmp_count = 0;
        cyc = 0;
        repeat (20) @(negedge clk);
        arst_n = 1'b1;
        refusals();
        band1_no_next();
        band2_pfi_marker_stalled();
        joined_short_zero_marker();
        band3_finalized();
        format_info_read();
        complete_run();
    end
endmodule
